// ### hdl/sfqp_core.sv
// serial flash core: quad read, page program, quad page program
`timescale 1ns/1ps
`default_nettype none
module sfqp_core
   import sfqp_pkg::*;
#(
   parameter int unsigned PROG_CYCLES =
      (PROG_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS
) (
   // core clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // link pins
   input wire logic link_clk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe_n,
   // configuration levels
   input wire logic quad_lines_enable_bit,
   input wire logic four_wire_command_mode,
   input wire logic wrap_enable,
   input wire logic [1:0] wrap_size,
   input wire logic [1:0] dummy_sel,
   // status
   output logic busy,
   output logic write_latch_flag
);
   // frame reset: chip select high clears the frame state
   logic frame_rst;
   assign frame_rst = rst | cs_n;

   // link frame state
   sfqp_link_state_t state_reg, state_next;
   logic [5:0] cnt_reg, cnt_next;
   logic [23:0] sh_reg, sh_next;
   logic [23:0] addr_reg, addr_next;
   logic quad_reg, quad_next;
   logic prog_reg, prog_next;
   logic [2:0] pos_reg, pos_next;
   logic [7:0] pidx_reg, pidx_next;
   // link state kept across frames
   logic cont_reg, cont_next;
   logic open_reg, open_next;
   logic armed_reg, armed_next;
   logic tag_reg, tag_next;
   logic [1:0] page_reg, page_next;
   logic tog_reg, tog_next;
   logic bpend_reg, bpend_next;
   logic lpend_reg, lpend_next;
   // configuration, latch and done crossings into the link domain
   logic [7:0] cfg_s1, cfg_s2;
   logic latch_s1, latch_s2;
   logic done_s1, done_s2, done_s3;
   logic done_tog_reg, done_tog_next;
   // link output registers
   logic [3:0] out_reg, out_next;
   logic [3:0] oe_reg, oe_next;
   // memory ports
   logic buf_we;
   logic [BUF_DW-1:0] buf_rdata;
   logic [7:0] arr_rdata;
   logic arr_we;
   logic [ARRAY_AW-1:0] arr_waddr;
   // helpers
   logic fw, qle, busy_now, latch_now;
   logic [5:0] dum_clks, c, c_inc;
   logic q;
   sfqp_link_state_t st;
   logic [23:0] sh_in, wmask, a_inc, a_adv;
   logic [7:0] stat;

   // configuration levels passed through two link flops
   always_comb begin
      fw = cfg_s2[1];
      qle = cfg_s2[0];
      case (cfg_s2[6:5])
         2'h0: dum_clks = FW_DUMMY_SEL0 - MODE_CLKS;
         2'h1: dum_clks = FW_DUMMY_SEL1 - MODE_CLKS;
         default: dum_clks = FW_DUMMY_SEL2 - MODE_CLKS;
      endcase
      if (!fw) begin
         dum_clks = ONE_WIRE_DUMMY_CLKS;
      end
      case (cfg_s2[4:3])
         2'h0: wmask = WRAP_MASK_8;
         2'h1: wmask = WRAP_MASK_16;
         2'h2: wmask = WRAP_MASK_32;
         default: wmask = WRAP_MASK_64;
      endcase
      a_inc = addr_reg + 24'h000001;
      // wrap only in one-wire command mode
      if (cfg_s2[2] && !fw) begin
         a_adv = (addr_reg & ~wmask) | (a_inc & wmask);
      end else begin
         a_adv = a_inc;
      end
   end

   // command decode and frame sequencing, rising link edge
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      addr_next = addr_reg;
      quad_next = quad_reg;
      prog_next = prog_reg;
      pos_next = pos_reg;
      pidx_next = pidx_reg;
      cont_next = cont_reg;
      open_next = open_reg;
      armed_next = 1'b0;
      tag_next = tag_reg;
      page_next = page_reg;
      tog_next = tog_reg;
      bpend_next = bpend_reg;
      lpend_next = lpend_reg;
      buf_we = 1'b0;
      st = state_reg;
      q = quad_reg;
      c = cnt_reg;
      // a just-committed program counts as busy at once
      busy_now = bpend_reg | (state_reg == L_START && armed_reg);
      if (done_s2 != done_s3) begin
         bpend_next = 1'b0;
      end
      if (latch_s2) begin
         lpend_next = 1'b0;
      end
      if (state_reg == L_START) begin
         c = 6'h00;
         if (armed_reg) begin
            bpend_next = 1'b1;
            lpend_next = 1'b0;
         end
         if (cont_reg && open_reg) begin
            // a continuation frame cut short resets the mode
            cont_next = 1'b0;
            open_next = 1'b0;
            st = L_CMD;
            q = fw;
         end else if (cont_reg) begin
            st = busy_now ? L_IGNORE : L_ADDR;
            q = 1'b1;
            prog_next = 1'b0;
            open_next = 1'b1;
         end else begin
            st = L_CMD;
            q = fw;
         end
      end
      latch_now = lpend_reg | latch_s2;
      state_next = st;
      quad_next = q;
      c_inc = c + 6'h01;
      // quad lines carry the high nibble first
      sh_in = q ? {sh_reg[19:0], io_in} : {sh_reg[22:0], io_in[0]};
      case (st)
         L_CMD: begin
            sh_next = sh_in;
            cnt_next = c_inc;
            if (c_inc == (fw ? CMD_CLKS_QUAD : CMD_CLKS_ONE)) begin
               cnt_next = 6'h00;
               state_next = L_IGNORE;
               case (sh_in[7:0])
                  CMD_WRITE_PERMIT: begin
                     tog_next = ~tog_reg;
                     lpend_next = 1'b1;
                  end
                  CMD_READ_STATUS: begin
                     state_next = L_STAT;
                     pos_next = 3'h0;
                  end
                  CMD_QUAD_READ: begin
                     if (qle && !busy_now) begin
                        state_next = L_ADDR;
                        quad_next = 1'b1;
                        prog_next = 1'b0;
                     end
                  end
                  CMD_PAGE_PROG: begin
                     if (latch_now && !busy_now) begin
                        state_next = L_ADDR;
                        prog_next = 1'b1;
                        tag_next = ~tag_reg;
                     end
                  end
                  CMD_QUAD_PROG: begin
                     if (qle && latch_now && !busy_now) begin
                        state_next = L_ADDR;
                        quad_next = 1'b1;
                        prog_next = 1'b1;
                        tag_next = ~tag_reg;
                     end
                  end
                  default: state_next = L_IGNORE;
               endcase
            end
         end
         L_ADDR: begin
            sh_next = sh_in;
            cnt_next = c_inc;
            if (c_inc == (q ? ADDR_CLKS_QUAD : ADDR_CLKS_ONE)) begin
               cnt_next = 6'h00;
               addr_next = sh_in;
               if (prog_reg) begin
                  state_next = L_PDATA;
                  pidx_next = sh_in[PAGE_AW-1:0];
                  page_next = sh_in[ARRAY_AW-1:PAGE_AW];
               end else begin
                  state_next = L_MODE;
               end
            end
         end
         L_MODE: begin
            sh_next = sh_in;
            cnt_next = c_inc;
            if (c_inc == MODE_CLKS) begin
               cnt_next = 6'h00;
               open_next = 1'b0;
               // low nibble is ignored
               cont_next = (sh_in[7:4] == CONT_KEEP);
               pos_next = 3'h0;
               // in four-wire command mode the continuation clocks are part of the dummy count
               state_next = (dum_clks == 6'h00) ? L_RDATA : L_DUMMY;
            end
         end
         L_DUMMY: begin
            cnt_next = c_inc;
            if (c_inc == dum_clks) begin
               cnt_next = 6'h00;
               state_next = L_RDATA;
            end
         end
         L_RDATA: begin
            pos_next = pos_reg + POS_STEP_QUAD;
            if (pos_reg[2]) begin
               addr_next = a_adv;
            end
         end
         L_STAT: begin
            pos_next = pos_reg + (q ? POS_STEP_QUAD : POS_STEP_ONE);
         end
         L_PDATA: begin
            sh_next = sh_in;
            cnt_next = c_inc;
            if (c_inc == (q ? BYTE_CLKS_QUAD : BYTE_CLKS_ONE)) begin
               cnt_next = 6'h00;
               buf_we = 1'b1;
               pidx_next = pidx_reg + 8'h01;
               armed_next = 1'b1;
            end
         end
         default: ;
      endcase
   end

   // frame registers, cleared while chip select is high
   always_ff @(posedge link_clk or posedge frame_rst) begin
      if (frame_rst) begin
         state_reg <= L_START;
         cnt_reg <= 6'h00;
         sh_reg <= 24'h000000;
         addr_reg <= 24'h000000;
         quad_reg <= 1'b0;
         prog_reg <= 1'b0;
         pos_reg <= 3'h0;
         pidx_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         addr_reg <= addr_next;
         quad_reg <= quad_next;
         prog_reg <= prog_next;
         pos_reg <= pos_next;
         pidx_reg <= pidx_next;
      end
   end

   // link registers that outlive a frame, plus the incoming crossings
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         cont_reg <= 1'b0;
         open_reg <= 1'b0;
         armed_reg <= 1'b0;
         tag_reg <= 1'b0;
         page_reg <= 2'h0;
         tog_reg <= 1'b0;
         bpend_reg <= 1'b0;
         lpend_reg <= 1'b0;
         cfg_s1 <= 8'h00;
         cfg_s2 <= 8'h00;
         latch_s1 <= 1'b0;
         latch_s2 <= 1'b0;
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
      end else begin
         cont_reg <= cont_next;
         open_reg <= open_next;
         armed_reg <= armed_next;
         tag_reg <= tag_next;
         page_reg <= page_next;
         tog_reg <= tog_next;
         bpend_reg <= bpend_next;
         lpend_reg <= lpend_next;
         cfg_s1 <= {1'b0, dummy_sel, wrap_size, wrap_enable,
                    four_wire_command_mode, quad_lines_enable_bit};
         cfg_s2 <= cfg_s1;
         latch_s1 <= write_latch_flag;
         latch_s2 <= latch_s1;
         done_s1 <= done_tog_reg;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
      end
   end

   // pin drive, chosen for the falling link edge
   always_comb begin
      stat = 8'h00;
      stat[STAT_BUSY] = bpend_reg;
      stat[STAT_LATCH] = lpend_reg | latch_s2;
      out_next = 4'h0;
      oe_next = 4'hf;
      if (state_reg == L_RDATA) begin
         out_next = pos_reg[2] ? arr_rdata[3:0] : arr_rdata[7:4];
         oe_next = 4'h0;
      end else if (state_reg == L_STAT && quad_reg) begin
         out_next = pos_reg[2] ? stat[3:0] : stat[7:4];
         oe_next = 4'h0;
      end else if (state_reg == L_STAT) begin
         out_next[SO_LINE] = stat[POS_LAST_BIT - pos_reg];
         oe_next[SO_LINE] = 1'b0;
      end
   end

   // output flops change on the falling edge so the host samples on rising
   always_ff @(negedge link_clk or posedge frame_rst) begin
      if (frame_rst) begin
         out_reg <= 4'h0;
         oe_reg <= 4'hf;
      end else begin
         out_reg <= out_next;
         oe_reg <= oe_next;
      end
   end
   assign io_out = out_reg;
   assign io_oe_n = oe_reg;

   // core side: program cycle
   sfqp_core_state_t cst_reg, cst_next;
   logic [8:0] idx_reg, idx_next;
   logic [23:0] tmr_reg, tmr_next;
   logic busy_reg, busy_next;
   logic latch_reg, latch_next;
   logic cs_s1, cs_s2, cs_s3;
   logic arm_s1, arm_s2;
   logic wt_s1, wt_s2, wt_s3;
   logic tag_s1, tag_s2;
   logic [1:0] pg_s1, pg_s2;
   logic start;
   logic [7:0] prev_idx;

   // sequencing of busy, latch flag and the page copy
   always_comb begin
      cst_next = cst_reg;
      idx_next = idx_reg;
      tmr_next = tmr_reg;
      busy_next = busy_reg;
      latch_next = latch_reg;
      done_tog_next = done_tog_reg;
      arr_we = 1'b0;
      prev_idx = idx_reg[7:0] - 8'h01;
      arr_waddr = {pg_s2, prev_idx};
      // commit only on chip select rise after a whole last byte
      start = cs_s2 & ~cs_s3 & arm_s2 & (cst_reg == C_IDLE);
      case (cst_reg)
         C_IDLE: begin
            if (start) begin
               busy_next = 1'b1;
               latch_next = 1'b0;
               idx_next = 9'h000;
               cst_next = C_COPY;
            end
         end
         C_COPY: begin
            idx_next = idx_reg + 9'h001;
            // bytes sent in this command carry the current tag, as do leftovers from an even number of program commands back
            if (idx_reg != 9'h000 && buf_rdata[BUF_DW-1] == tag_s2) begin
               arr_we = 1'b1;
            end
            if (idx_reg == PAGE_BYTES) begin
               tmr_next = 24'h000000;
               cst_next = C_WAIT;
            end
         end
         C_WAIT: begin
            tmr_next = tmr_reg + 24'h000001;
            if (tmr_next == 24'(PROG_CYCLES)) begin
               busy_next = 1'b0;
               done_tog_next = ~done_tog_reg;
               cst_next = C_IDLE;
            end
         end
         default: cst_next = C_IDLE;
      endcase
      // permit set wins over the busy-start clear
      if (wt_s2 != wt_s3) begin
         latch_next = 1'b1;
      end
   end

   // core registers and link-to-core crossings
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cst_reg <= C_IDLE;
         idx_reg <= 9'h000;
         tmr_reg <= 24'h000000;
         busy_reg <= 1'b0;
         latch_reg <= 1'b0;
         done_tog_reg <= 1'b0;
         {cs_s1, cs_s2, cs_s3} <= 3'h7;
         {arm_s1, arm_s2} <= 2'h0;
         {wt_s1, wt_s2, wt_s3} <= 3'h0;
         {tag_s1, tag_s2} <= 2'h0;
         pg_s1 <= 2'h0;
         pg_s2 <= 2'h0;
      end else begin
         cst_reg <= cst_next;
         idx_reg <= idx_next;
         tmr_reg <= tmr_next;
         busy_reg <= busy_next;
         latch_reg <= latch_next;
         done_tog_reg <= done_tog_next;
         {cs_s1, cs_s2, cs_s3} <= {cs_n, cs_s1, cs_s2};
         {arm_s1, arm_s2} <= {armed_reg, arm_s1};
         {wt_s1, wt_s2, wt_s3} <= {tog_reg, wt_s1, wt_s2};
         {tag_s1, tag_s2} <= {tag_reg, tag_s1};
         pg_s1 <= page_reg;
         pg_s2 <= pg_s1;
      end
   end
   assign busy = busy_reg;
   assign write_latch_flag = latch_reg;

   // page buffer: link writes, core reads during the copy
   sfqp_dpram #(.DW(BUF_DW), .AW(PAGE_AW)) u_page_buf (
      .wclk(link_clk),
      .we(buf_we),
      .waddr(pidx_reg),
      .wdata({tag_reg, sh_next[7:0]}),
      .rclk(core_clk),
      .raddr(idx_reg[7:0]),
      .rdata(buf_rdata)
   );

   // array: core writes, link reads the address it is about to use
   sfqp_dpram #(.DW(8), .AW(ARRAY_AW)) u_array (
      .wclk(core_clk),
      .we(arr_we),
      .waddr(arr_waddr),
      .wdata(buf_rdata[7:0]),
      .rclk(link_clk),
      .raddr(addr_next[ARRAY_AW-1:0]),
      .rdata(arr_rdata)
   );
endmodule : sfqp_core
`default_nettype wire

// ### hdl/sfqp_dpram.sv
// two-clock memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sfqp_dpram #(
   parameter int DW = 8,
   parameter int AW = 8
) (
   // write side
   input wire logic wclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // read side
   input wire logic rclk,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   // storage, no reset so it maps onto block memory
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // write port
   always_ff @(posedge wclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // read port, data one edge after the address
   always_ff @(posedge rclk) begin
      rdata <= mem[raddr];
   end
endmodule : sfqp_dpram
`default_nettype wire

// ### hdl/sfqp_pkg.sv
// shared constants and types of the serial flash quad read / program core
package sfqp_pkg;
   // command bytes
   localparam logic [7:0] CMD_QUAD_READ = 8'heb;
   localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
   localparam logic [7:0] CMD_QUAD_PROG = 8'h33;
   localparam logic [7:0] CMD_WRITE_PERMIT = 8'h06;
   localparam logic [7:0] CMD_READ_STATUS = 8'h05;
   // continuation nibble that keeps the command byte away
   localparam logic [3:0] CONT_KEEP = 4'ha;
   // clocks per phase
   localparam logic [5:0] CMD_CLKS_ONE = 6'h08;
   localparam logic [5:0] CMD_CLKS_QUAD = 6'h02;
   localparam logic [5:0] ADDR_CLKS_ONE = 6'h18;
   localparam logic [5:0] ADDR_CLKS_QUAD = 6'h06;
   localparam logic [5:0] MODE_CLKS = 6'h02;
   localparam logic [5:0] BYTE_CLKS_ONE = 6'h08;
   localparam logic [5:0] BYTE_CLKS_QUAD = 6'h02;
   localparam logic [5:0] ONE_WIRE_DUMMY_CLKS = 6'h04;
   localparam logic [5:0] FW_DUMMY_SEL0 = 6'h04;
   localparam logic [5:0] FW_DUMMY_SEL1 = 6'h06;
   localparam logic [5:0] FW_DUMMY_SEL2 = 6'h08;
   // wrap section masks: 8, 16, 32, 64 bytes
   localparam logic [23:0] WRAP_MASK_8 = 24'h000007;
   localparam logic [23:0] WRAP_MASK_16 = 24'h00000f;
   localparam logic [23:0] WRAP_MASK_32 = 24'h00001f;
   localparam logic [23:0] WRAP_MASK_64 = 24'h00003f;
   // output nibble position step and serial data-out line
   localparam logic [2:0] POS_STEP_QUAD = 3'h4;
   localparam logic [2:0] POS_STEP_ONE = 3'h1;
   localparam logic [2:0] POS_LAST_BIT = 3'h7;
   localparam int SO_LINE = 1;
   // status byte fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_LATCH = 1;
   // storage geometry
   localparam int PAGE_AW = 8;
   localparam int ARRAY_AW = 10;
   localparam int BUF_DW = 9;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   // program cycle time
   localparam int PROG_TIME_NS = 100000;
   localparam int CORE_CLK_NS = 10;
   // link side states
   typedef enum logic [3:0] {
      L_START, L_CMD, L_ADDR, L_MODE, L_DUMMY, L_RDATA, L_PDATA, L_STAT,
      L_IGNORE
   } sfqp_link_state_t;
   // core side states
   typedef enum logic [1:0] {C_IDLE, C_COPY, C_WAIT} sfqp_core_state_t;
endpackage : sfqp_pkg

// ### tb/sfqp_core_sva.sv
// assertion checker bound to the serial flash core ports
`timescale 1ns/1ps
`default_nettype none
module sfqp_core_sva #(
   parameter int unsigned PROG_CYCLES = 20
) (
   // clocks, reset and link pins
   input wire logic core_clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe_n,
   // configuration levels
   input wire logic quad_lines_enable_bit,
   input wire logic four_wire_command_mode,
   input wire logic wrap_enable,
   input wire logic [1:0] wrap_size,
   input wire logic [1:0] dummy_sel,
   // status
   input wire logic busy,
   input wire logic write_latch_flag
);
   logic [15:0] bcnt_reg, bcnt_next; // length of the running busy spell
   // count busy cycles; a stuck busy would otherwise go unseen
   always_comb begin
      bcnt_next = busy ? bcnt_reg + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bcnt_reg <= 16'h0000;
      end else begin
         bcnt_reg <= bcnt_next;
      end
   end
   a_reset_quiet: assert property (@(posedge core_clk)
      rst |-> !busy && !write_latch_flag && io_oe_n == 4'hf)
      else $error("outputs active in reset");
   a_cs_release: assert property (@(posedge core_clk) disable iff (rst)
      cs_n |-> io_oe_n == 4'hf) else $error("driving while deselected");
   a_busy_latch: assert property (@(posedge core_clk) disable iff (rst)
      $rose(busy) |-> !write_latch_flag) else $error("latch kept at busy");
   a_busy_permit: assert property (@(posedge core_clk) disable iff (rst)
      $rose(busy) |-> $past(write_latch_flag))
      else $error("program without latch");
   a_busy_min: assert property (@(posedge core_clk) disable iff (rst)
      $rose(busy) |-> cs_n ##0 busy[*8]) else $error("busy too short");
   a_busy_bound: assert property (@(posedge core_clk) disable iff (rst)
      bcnt_reg <= 16'(257 + PROG_CYCLES + 16)) else $error("busy too long");
   a_read_busy: assert property (@(posedge core_clk) disable iff (rst)
      busy && !four_wire_command_mode |-> io_oe_n[0] && io_oe_n[3:2] == 2'h3)
      else $error("read served while busy");
   a_quad_off: assert property (@(posedge core_clk) disable iff (rst)
      !quad_lines_enable_bit && !four_wire_command_mode && !cs_n
      |-> io_oe_n[3:2] == 2'h3) else $error("quad read without enable");
   a_oe_shape: assert property (@(posedge link_clk) disable iff (rst)
      io_oe_n inside {4'hf, 4'h0, 4'hd}) else $error("odd enable pattern");
endmodule : sfqp_core_sva
bind sfqp_core sfqp_core_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
   .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .cs_n(cs_n),
   .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
   .quad_lines_enable_bit(quad_lines_enable_bit),
   .four_wire_command_mode(four_wire_command_mode),
   .wrap_enable(wrap_enable), .wrap_size(wrap_size),
   .dummy_sel(dummy_sel), .busy(busy), .write_latch_flag(write_latch_flag));
`default_nettype wire

// ### tb/sfqp_host.sv
// host controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module sfqp_host
   import sfqp_pkg::*;
(
   // link pins
   output logic link_clk,
   output logic cs_n,
   output logic [3:0] io_in,
   // device drive
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe_n
);
   logic [3:0] hv, hen, junk, smp; // host value, enable, float, sample
   logic drove; // device drove a line this frame
   // released wires float: show a changing pattern, never the last value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io_in[i] = !io_oe_n[i] ? io_out[i] : hen[i] ? hv[i] : junk[i];
      end
   end
   initial begin
      link_clk = 1'b0;
      cs_n = 1'b1;
      hv = 4'h0;
      hen = 4'h0;
      junk = 4'h5;
   end
   // one clock: drive after falling edge, sample at rising edge
   task automatic tick(input logic [3:0] v, input logic [3:0] en);
      hv = v;
      hen = en;
      junk = ~junk;
      #15 link_clk = 1'b1;
      smp = io_in;
      if (io_oe_n != 4'hf) drove = 1'b1;
      #15 link_clk = 1'b0;
   endtask : tick
   task automatic sel();
      #7 cs_n = 1'b0;
      drove = 1'b0;
   endtask : sel
   // clock idles low between frames, gap covers ten core clocks
   task automatic desel();
      #10 cs_n = 1'b1;
      hen = 4'h0;
      #100;
   endtask : desel
   task automatic byte1(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) tick({3'h0, b[i]}, 4'h1);
   endtask : byte1
   // nibbles msb first on IO3..IO0
   task automatic quadw(input int n, input logic [23:0] v);
      for (int i = n - 1; i >= 0; i--) tick(v[4*i+:4], 4'hf);
   endtask : quadw
   task automatic cmd(input logic [7:0] b, input logic fw);
      if (fw) quadw(2, {16'h0000, b});
      else byte1(b);
   endtask : cmd
   // lines released before the first data falling edge
   task automatic quadr(input int n, output logic [31:0] d);
      d = '0;
      for (int i = 0; i < 2 * n; i++) begin
         tick(4'h0, 4'h0);
         d = {d[27:0], smp};
      end
   endtask : quadr
   task automatic stat(output logic [7:0] s);
      sel();
      cmd(CMD_READ_STATUS, 1'b0);
      s = '0;
      for (int i = 0; i < 8; i++) begin
         tick(4'h0, 4'h0);
         s = {s[6:0], smp[SO_LINE]};
      end
      desel();
   endtask : stat
endmodule : sfqp_host
`default_nettype wire

// ### tb/sfqp_tb_top.sv
// self-checking bench for the serial flash core
`timescale 1ns/1ps
`default_nettype none
module sfqp_tb_top
   import sfqp_pkg::*;
;
   logic core_clk, rst, link_clk, cs_n, busy, write_latch_flag;
   logic quad_lines_enable_bit, four_wire_command_mode, wrap_enable;
   logic [1:0] wrap_size, dummy_sel;
   logic [3:0] io_in, io_out, io_oe_n;
   logic [7:0] st; // status byte read back
   int err_count = 0;
   int n_compared = 0;
   // short program time keeps the run brief
   sfqp_core #(.PROG_CYCLES(20)) DUT (.core_clk(core_clk), .rst(rst),
      .link_clk(link_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
      .io_oe_n(io_oe_n), .quad_lines_enable_bit(quad_lines_enable_bit),
      .four_wire_command_mode(four_wire_command_mode),
      .wrap_enable(wrap_enable), .wrap_size(wrap_size),
      .dummy_sel(dummy_sel), .busy(busy), .write_latch_flag(write_latch_flag));
   sfqp_host host (.link_clk(link_clk), .cs_n(cs_n), .io_in(io_in),
      .io_out(io_out), .io_oe_n(io_oe_n));
   always #5 core_clk = ~core_clk;
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   // wait for busy (s=1) or the latch (s=0) to reach v, bounded
   task automatic wt(input logic s, input logic v);
      int i;
      for (i = 0; i < 2000; i++) begin
         @(negedge core_clk);
         if ((s ? busy : write_latch_flag) === v) break;
      end
      chk(i < 2000, "status wait ran out");
   endtask : wt
   // config passes link flops, so a null frame follows each change
   task automatic cfg(input logic qe, fw, we, input logic [1:0] ws, ds);
      @(negedge core_clk);
      quad_lines_enable_bit = qe;
      four_wire_command_mode = fw;
      wrap_enable = we;
      wrap_size = ws;
      dummy_sel = ds;
      host.sel();
      repeat (8) host.tick(4'h0, 4'hf);
      host.desel();
   endtask : cfg
   task automatic permit();
      host.sel();
      host.cmd(CMD_WRITE_PERMIT, 1'b0);
      host.desel();
      wt(1'b0, 1'b1);
   endtask : permit
   // quad read; expected byte is its address xor 5a
   task automatic qread(input logic fw, sk, ok, input logic [23:0] a,
         input logic [7:0] ct, input int dm, n, input logic [23:0] wm);
      logic [31:0] d;
      logic [23:0] ea;
      host.sel();
      if (!sk) host.cmd(CMD_QUAD_READ, fw);
      host.quadw(6, a);
      host.quadw(2, {16'h0000, ct});
      repeat (dm) host.tick(4'h0, 4'h0);
      host.quadr(n, d);
      host.desel();
      if (!ok) chk(host.drove === 1'b0, "refused read drove a line");
      for (int i = 0; ok && i < n; i++) begin
         ea = (a & ~wm) | ((a + 24'(i)) & wm);
         chk(d[8*(n-1-i)+:8] === (ea[7:0] ^ 8'h5a), "read byte");
      end
   endtask : qread
   // program n bytes from a, then pb stray bits
   task automatic prog(input logic q, input logic [23:0] a, input int n, pb);
      host.sel();
      host.cmd(q ? CMD_QUAD_PROG : CMD_PAGE_PROG, 1'b0);
      if (q) host.quadw(6, a);
      else for (int i = 2; i >= 0; i--) host.byte1(a[8*i+:8]);
      for (int i = 0; i < n; i++) begin
         if (q) host.quadw(2, {16'h0000, (a[7:0] + 8'(i)) ^ 8'h5a});
         else host.byte1((a[7:0] + 8'(i)) ^ 8'h5a);
      end
      repeat (pb) host.tick(4'h0, 4'h1);
      host.desel();
   endtask : prog
   initial begin
      #500000;
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      {quad_lines_enable_bit, four_wire_command_mode, wrap_enable} = 3'h0;
      wrap_size = 2'h0;
      dummy_sel = 2'h0;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      cfg(1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
      qread(1'b0, 1'b0, 1'b0, 24'h0, 8'h00, 4, 1, 24'hffffff);
      $display("test refusal done");
      cfg(1'b1, 1'b0, 1'b0, 2'h0, 2'h0);
      permit();
      prog(1'b1, 24'h000000, 64, 0);
      wt(1'b1, 1'b1);
      chk(write_latch_flag === 1'b0, "latch kept");
      qread(1'b0, 1'b0, 1'b0, 24'h10, 8'h00, 4, 1, 24'hffffff);
      host.stat(st);
      chk(st[1:0] === 2'b01, "status during program");
      wt(1'b1, 1'b0);
      permit();
      prog(1'b0, 24'h0000fe, 1, 4);
      repeat (50) @(negedge core_clk);
      chk(busy === 1'b0 && write_latch_flag === 1'b1, "partial ran");
      prog(1'b0, 24'h0000fe, 3, 0);
      wt(1'b1, 1'b1);
      wt(1'b1, 1'b0);
      $display("test program done");
      qread(1'b0, 1'b0, 1'b1, 24'hfe, 8'ha7, 4, 2, 24'hffffff);
      qread(1'b0, 1'b1, 1'b1, 24'h0, 8'ha5, 4, 1, 24'hffffff);
      host.sel();
      repeat (3) host.tick(4'h0, 4'hf);
      host.desel();
      qread(1'b0, 1'b0, 1'b1, 24'h5, 8'h00, 4, 1, 24'hffffff);
      for (int k = 0; k < 4; k++) begin
         cfg(1'b1, 1'b0, 1'b1, 2'(k), 2'h0);
         qread(1'b0, 1'b0, 1'b1, 24'h3e, 8'h00, 4, 4,
            24'((24'h8 << k) - 1));
      end
      $display("test wrap done");
      for (int s = 0; s < 3; s++) begin
         cfg(1'b1, 1'b1, 1'b1, 2'h0, 2'(s));
         qread(1'b1, 1'b0, 1'b1, 24'h1e, 8'h00, 2*s+2, 4, 24'hffffff);
      end
      $display("test four-wire done");
      conclude();
   end
endmodule : sfqp_tb_top
`default_nettype wire
